// >>> src/pet_edge_trim.sv
// edge seven to ten offset trim registers behind apb, feeding the pwm edge generator
//
// What this block does
// R01: polarity bit set means negative offset
// R02: first register bits 6:4 trim edge seven
// R03: first register bits 2:0 trim edge eight
// R04: second register bits 6:4 trim edge nine
// R05: second register bits 2:0 trim edge ten
//
// software writes land in staging registers; they reach the edge outputs
// at once (immediate mode), on an apply strobe, or at the next pwm period
// start, so with neither immediate mode nor an apply strobe the edge generator never sees a half-updated pair of edges within a period.
//
// Our own choice: the APB slave port.
module pet_edge_trim #(
    parameter logic [7:0] TRIM_78_RESET  = pet_pkg::PET_TRIM_78_RST,
    parameter logic [7:0] TRIM_910_RESET = pet_pkg::PET_TRIM_910_RST,
    parameter int         STEP_NS        = pet_pkg::PET_STEP_NS
) (
    input  wire logic                             clk,
    input  wire logic                             rst,
    input  pet_pkg::pet_apb_req_s                 apb_req,
    output pet_pkg::pet_apb_rsp_s                 apb_rsp,
    input  wire logic                             period_start,
    output pet_pkg::pet_edge_s                    edge_out [pet_pkg::PET_NUM_EDGES],
    output wire logic [pet_pkg::PET_NUM_TRIMS-1:0] update_pending,
    output wire logic                             trim_applied
);
    import pet_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // elaboration checks

    if (STEP_NS < 1 || STEP_NS * 7 > 63) begin : g_step_chk
        $error("step size does not fit the signed offset width");
    end

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // picks the four-bit field of one edge out of its trim register
    function automatic logic [PET_FIELD_W-1:0] pet_field(input logic [PET_REG_W-1:0] r,
                                                         input logic hi);
        return hi ? r[PET_HI_LSB +: PET_FIELD_W] : r[PET_LO_LSB +: PET_FIELD_W];
    endfunction

    // places an eight-bit value into a read word at a given position
    function automatic logic [31:0] pet_place(input logic [PET_REG_W-1:0] v, input int lsb);
        return 32'(v) << lsb;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    logic [PET_REG_W-1:0]     stage_q [PET_NUM_TRIMS];
    logic [PET_REG_W-1:0]     stage_d [PET_NUM_TRIMS];
    logic [PET_REG_W-1:0]     active_q [PET_NUM_TRIMS];
    logic [PET_REG_W-1:0]     active_d [PET_NUM_TRIMS];
    logic [PET_NUM_TRIMS-1:0] pend_q;
    logic [PET_NUM_TRIMS-1:0] pend_d;
    logic                     imm_q;
    logic                     apply_req_q;
    logic                     applied_q;
    pet_edge_s                edge_q [PET_NUM_EDGES];
    pet_edge_s                edge_dec [PET_NUM_EDGES];

    wire logic                wr_en;
    wire logic                setup;
    wire logic                hit_78;
    wire logic                hit_910;
    wire logic                hit_ctrl;
    wire logic                hit_status;
    wire logic                addr_err;
    wire logic                wr_78;
    wire logic                wr_910;
    wire logic                wr_ctrl;
    wire logic                apply_now;
    wire logic [31:0]         rd_data;
    wire logic [31:0]         ctrl_word;
    wire logic [31:0]         status_word;
    wire logic [PET_REG_W-1:0] wdata8;

    ////////////////////////////////////////////////////////////////////////////
    // apb handshake

    pet_apb_slave u_apb (
        .clk      (clk),
        .rst      (rst),
        .apb_req  (apb_req),
        .apb_rsp  (apb_rsp),
        .rd_data  (rd_data),
        .addr_err (addr_err),
        .wr_en    (wr_en),
        .setup    (setup)
    );

    ////////////////////////////////////////////////////////////////////////////
    // address decode

    assign hit_78     = apb_req.paddr == PET_ADDR_TRIM_78;
    assign hit_910    = apb_req.paddr == PET_ADDR_TRIM_910;
    assign hit_ctrl   = apb_req.paddr == PET_ADDR_CTRL;
    assign hit_status = apb_req.paddr == PET_ADDR_STATUS;
    assign addr_err   = ~(hit_78 | hit_910 | hit_ctrl | hit_status);

    assign wdata8  = apb_req.pwdata[PET_REG_W-1:0];
    assign wr_78   = wr_en & hit_78;
    assign wr_910  = wr_en & hit_910;
    // status is read only; a write to it is accepted and has no effect
    assign wr_ctrl = wr_en & hit_ctrl;

    ////////////////////////////////////////////////////////////////////////////
    // read mux

    assign ctrl_word = {30'h00000000, 1'b0, imm_q};

    assign status_word = pet_place(active_q[1], PET_STAT_ACT910_LSB)
                       | pet_place(active_q[0], PET_STAT_ACT78_LSB)
                       | 32'(pend_q);

    assign rd_data = hit_78     ? 32'(stage_q[0]) :
                     hit_910    ? 32'(stage_q[1]) :
                     hit_ctrl   ? ctrl_word :
                     hit_status ? status_word :
                     32'h00000000;

    ////////////////////////////////////////////////////////////////////////////
    // control register

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            imm_q <= PET_CTRL_RST[PET_CTRL_IMM_BIT];
        end else if (wr_ctrl) begin
            imm_q <= apb_req.pwdata[PET_CTRL_IMM_BIT];
        end
    end

    // apply strobe is self clearing and reads back as zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            apply_req_q <= PET_CTRL_RST[PET_CTRL_APPLY_BIT];
        end else begin
            apply_req_q <= wr_ctrl & apb_req.pwdata[PET_CTRL_APPLY_BIT];
        end
    end

    // staging reaches the edges at period start, on request, or always in immediate mode
    assign apply_now = period_start | apply_req_q | imm_q;

    ////////////////////////////////////////////////////////////////////////////
    // staging and active trim registers

    always_comb begin
        stage_d[0] = wr_78  ? wdata8 : stage_q[0];
        stage_d[1] = wr_910 ? wdata8 : stage_q[1];
    end

    // apply copies the staging value held before this edge; a write in the
    // same cycle lands in staging and stays pending for the next apply
    always_comb begin
        for (int i = 0; i < PET_NUM_TRIMS; i++) begin
            active_d[i] = apply_now ? stage_q[i] : active_q[i];
        end
    end

    // a fresh write sets pending even when an apply clears it in the same cycle
    always_comb begin
        pend_d = apply_now ? '0 : pend_q;
        if (wr_78) begin
            pend_d[0] = 1'b1;
        end
        if (wr_910) begin
            pend_d[1] = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stage_q[0]  <= TRIM_78_RESET;
            stage_q[1]  <= TRIM_910_RESET;
            active_q[0] <= TRIM_78_RESET;
            active_q[1] <= TRIM_910_RESET;
            pend_q      <= '0;
        end else begin
            stage_q  <= stage_d;
            active_q <= active_d;
            pend_q   <= pend_d;
        end
    end

    // one-cycle pulse after any active value actually changed
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            applied_q <= 1'b0;
        end else begin
            applied_q <= (active_d[0] != active_q[0]) | (active_d[1] != active_q[1]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // edge field decode

    pet_edge_decode #(.STEP_NS(STEP_NS)) u_edge7 (
        .field  (pet_field(active_q[0], 1'b1)),        // R02
        .edge_o (edge_dec[0])
    );

    pet_edge_decode #(.STEP_NS(STEP_NS)) u_edge8 (
        .field  (pet_field(active_q[0], 1'b0)),        // R03
        .edge_o (edge_dec[1])
    );

    pet_edge_decode #(.STEP_NS(STEP_NS)) u_edge9 (
        .field  (pet_field(active_q[1], 1'b1)),        // R04
        .edge_o (edge_dec[2])
    );

    pet_edge_decode #(.STEP_NS(STEP_NS)) u_edge10 (
        .field  (pet_field(active_q[1], 1'b0)),        // R05
        .edge_o (edge_dec[3])
    );

    ////////////////////////////////////////////////////////////////////////////
    // registered edge outputs

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < PET_NUM_EDGES; i++) begin
                edge_q[i] <= '0;
            end
        end else begin
            edge_q <= edge_dec;                        // R01
        end
    end

    assign edge_out       = edge_q;
    assign update_pending = pend_q;
    assign trim_applied   = applied_q;

endmodule

// >>> include/pet_pkg.sv
// constants and carrier types for the pwm edge offset trim block
package pet_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register indices; a word's byte address is four times its index
    localparam int         PET_ADDR_W       = 12;
    localparam logic [7:0] PET_IDX_TRIM_78  = 8'h6C;
    localparam logic [7:0] PET_IDX_TRIM_910 = 8'h6D;
    localparam logic [7:0] PET_IDX_CTRL     = 8'h70;
    localparam logic [7:0] PET_IDX_STATUS   = 8'h71;

    function automatic logic [PET_ADDR_W-1:0] pet_byte_addr(input logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction

    localparam logic [PET_ADDR_W-1:0] PET_ADDR_TRIM_78  = pet_byte_addr(PET_IDX_TRIM_78);
    localparam logic [PET_ADDR_W-1:0] PET_ADDR_TRIM_910 = pet_byte_addr(PET_IDX_TRIM_910);
    localparam logic [PET_ADDR_W-1:0] PET_ADDR_CTRL     = pet_byte_addr(PET_IDX_CTRL);
    localparam logic [PET_ADDR_W-1:0] PET_ADDR_STATUS   = pet_byte_addr(PET_IDX_STATUS);

    ////////////////////////////////////////////////////////////////////////////
    // trim register field layout
    localparam int PET_REG_W      = 8;
    localparam int PET_FIELD_W    = 4;
    localparam int PET_OFS_W      = 3;
    localparam int PET_POL_BIT    = 3;
    localparam int PET_HI_LSB     = 4;
    localparam int PET_LO_LSB     = 0;
    localparam int PET_STEP_NS    = 5;
    localparam int PET_NUM_EDGES  = 4;
    localparam int PET_NUM_TRIMS  = 2;

    localparam logic [7:0] PET_TRIM_78_RST  = 8'h00;
    localparam logic [7:0] PET_TRIM_910_RST = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // control and status layout
    localparam int         PET_CTRL_IMM_BIT   = 0;
    localparam int         PET_CTRL_APPLY_BIT = 1;
    localparam logic [1:0] PET_CTRL_RST       = 2'h0;
    localparam int         PET_STAT_PEND_LSB  = 0;
    localparam int         PET_STAT_ACT78_LSB = 8;
    localparam int         PET_STAT_ACT910_LSB = 16;

    ////////////////////////////////////////////////////////////////////////////
    // carriers
    typedef struct packed {
        logic                  psel;
        logic                  penable;
        logic                  pwrite;
        logic [PET_ADDR_W-1:0] paddr;
        logic [31:0]           pwdata;
    } pet_apb_req_s;

    typedef struct packed {
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } pet_apb_rsp_s;

    typedef struct packed {
        logic              negative;
        logic [2:0]        code;
        logic signed [6:0] offset_ns;
    } pet_edge_s;

endpackage

// >>> src/pet_edge_decode.sv
// turns one four-bit trim field into polarity, code and signed offset in ns
module pet_edge_decode #(
    parameter int STEP_NS = pet_pkg::PET_STEP_NS
) (
    input  wire logic [pet_pkg::PET_FIELD_W-1:0] field,
    output pet_pkg::pet_edge_s                   edge_o
);
    import pet_pkg::*;

    if (STEP_NS < 1 || STEP_NS * 7 > 63) begin : g_step_chk
        $error("step size does not fit the signed offset width");
    end

    wire logic              pol_neg;
    wire logic [2:0]        code;
    wire logic signed [6:0] mag;

    assign pol_neg = field[PET_POL_BIT];
    assign code    = field[PET_OFS_W-1:0];
    assign mag     = 7'(int'(code) * STEP_NS);

    assign edge_o.negative  = pol_neg;                  // R01
    assign edge_o.code      = code;
    assign edge_o.offset_ns = pol_neg ? -mag : mag;     // R01
endmodule

// >>> src/pet_apb_slave.sv
// apb handshake: read data captured in setup, zero wait states in access
module pet_apb_slave (
    input  wire logic          clk,
    input  wire logic          rst,
    input  pet_pkg::pet_apb_req_s apb_req,
    output pet_pkg::pet_apb_rsp_s apb_rsp,
    input  wire logic [31:0]   rd_data,
    input  wire logic          addr_err,
    output wire logic          wr_en,
    output wire logic          setup
);
    import pet_pkg::*;

    logic [31:0] prdata_q;
    logic        pslverr_q;
    wire  logic  access;

    assign setup  = apb_req.psel & ~apb_req.penable;
    assign access = apb_req.psel & apb_req.penable;
    assign wr_en  = access & apb_req.pwrite & ~pslverr_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prdata_q  <= 32'h00000000;
            pslverr_q <= 1'b0;
        end else if (setup) begin
            prdata_q  <= apb_req.pwrite ? 32'h00000000 : rd_data;
            pslverr_q <= addr_err;
        end
    end

    assign apb_rsp.pready  = access;
    assign apb_rsp.prdata  = prdata_q;
    assign apb_rsp.pslverr = pslverr_q & access;
endmodule

// >>> sim/pet_edge_trim_asserts.sv
// concurrent checks on the ports of the edge offset trim block
module pet_edge_trim_asserts (
    input  wire logic                              clk,
    input  wire logic                              rst,
    input  pet_pkg::pet_apb_req_s                  apb_req,
    input  pet_pkg::pet_apb_rsp_s                  apb_rsp,
    input  wire logic                              period_start,
    input  pet_pkg::pet_edge_s                     edge_out [pet_pkg::PET_NUM_EDGES],
    input  wire logic [pet_pkg::PET_NUM_TRIMS-1:0] update_pending,
    input  wire logic                              trim_applied
);
    timeunit 1ns;
    timeprecision 1ns;
    import pet_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // shadow of the staged trim bytes, loaded by apb writes
    logic [7:0] s78_q;
    logic [7:0] s910_q;
    wire logic  acc_wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
    wire logic  wr_78  = acc_wr && apb_req.paddr == PET_ADDR_TRIM_78;
    wire logic  wr_910 = acc_wr && apb_req.paddr == PET_ADDR_TRIM_910;
    wire logic [3:0] f7  = s78_q[7:4];
    wire logic [3:0] f8  = s78_q[3:0];
    wire logic [3:0] f9  = s910_q[7:4];
    wire logic [3:0] f10 = s910_q[3:0];
    wire logic  mapped = apb_req.paddr inside {PET_ADDR_TRIM_78, PET_ADDR_TRIM_910,
                                               PET_ADDR_CTRL, PET_ADDR_STATUS};

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s78_q  <= PET_TRIM_78_RST;
            s910_q <= PET_TRIM_910_RST;
        end else begin
            if (wr_78) s78_q <= apb_req.pwdata[7:0];
            if (wr_910) s910_q <= apb_req.pwdata[7:0];
        end
    end

    function automatic logic ofs_ok(input pet_edge_s e);
        int v;
        v = int'(e.code) * 5;
        return int'(e.offset_ns) == (e.negative ? -v : v);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_sign;
        ofs_ok(edge_out[0]) && ofs_ok(edge_out[1]) && ofs_ok(edge_out[2]) && ofs_ok(edge_out[3]);
    endproperty
    property p_edge_seven;
        period_start |-> ##2 {edge_out[0].negative, edge_out[0].code} == $past(f7, 2);
    endproperty
    property p_edge_eight;
        period_start |-> ##2 {edge_out[1].negative, edge_out[1].code} == $past(f8, 2);
    endproperty
    property p_edge_nine;
        period_start |-> ##2 {edge_out[2].negative, edge_out[2].code} == $past(f9, 2);
    endproperty
    property p_edge_ten;
        period_start |-> ##2 {edge_out[3].negative, edge_out[3].code} == $past(f10, 2);
    endproperty
    property p_ready;
        apb_req.psel && apb_req.penable |-> apb_rsp.pready && (apb_rsp.pslverr == !mapped);
    endproperty
    property p_pending;
        wr_78 || wr_910 |=> (update_pending & $past({wr_910, wr_78})) == $past({wr_910, wr_78});
    endproperty

    a_sign: assert property (p_sign)
        else $error("edge offset sign or magnitude wrong");
    a_edge_seven: assert property (p_edge_seven)
        else $error("edge seven not taken from staged bits 7:4");
    a_edge_eight: assert property (p_edge_eight)
        else $error("edge eight not taken from staged bits 3:0");
    a_edge_nine: assert property (p_edge_nine)
        else $error("edge nine not taken from staged bits 7:4");
    a_edge_ten: assert property (p_edge_ten)
        else $error("edge ten not taken from staged bits 3:0");
    a_ready: assert property (p_ready)
        else $error("access cycle without ready or with wrong error flag");
    a_pending: assert property (p_pending)
        else $error("trim write did not raise its pending flag");

    c_apply: cover property (period_start ##1 trim_applied);
    c_error: cover property (apb_rsp.pslverr);
    c_pending: cover property (update_pending != 2'b00);
endmodule

bind pet_edge_trim pet_edge_trim_asserts u_pet_edge_trim_asserts (
    .clk(clk), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp), .period_start(period_start),
    .edge_out(edge_out), .update_pending(update_pending), .trim_applied(trim_applied)
);

// >>> sim/testbench.sv
// self-checking bench for the pwm edge offset trim block
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_total++; $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import pet_pkg::*;

    logic         clk          = 1'b0;
    logic         rst          = 1'b1;
    logic         period_start = 1'b0;
    pet_apb_req_s req          = '0;
    pet_apb_rsp_s rsp;
    pet_edge_s    eo [PET_NUM_EDGES];
    logic [1:0]   pend;
    logic         applied;
    int           err_total    = 0;
    int           total_checks = 0;
    logic [31:0]  seed         = 32'h098828B6;
    int           stage [2];
    int           act [2];
    logic [31:0]  rd;
    logic         er;

    always #50 clk = ~clk;

    pet_edge_trim u_pet_edge_trim (.clk(clk), .rst(rst), .apb_req(req), .apb_rsp(rsp),
        .period_start(period_start), .edge_out(eo), .update_pending(pend), .trim_applied(applied));

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xorshift();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // one apb transfer; setup after an idle edge so release and setup never share a step
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= wr;
        req.paddr <= a;
        req.pwdata <= d;
        @(posedge clk);
        req.penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        er = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask

    task automatic put(input int r, input logic [7:0] d);
        apb(1'b1, r ? PET_ADDR_TRIM_910 : PET_ADDR_TRIM_78, {24'h0, d});
        stage[r] = d;
    endtask

    task automatic get(input int r);
        apb(1'b0, r ? PET_ADDR_TRIM_910 : PET_ADDR_TRIM_78, 32'h0);
        `CHK({er, rd}, {1'b0, 32'(stage[r])})
    endtask

    task automatic pulse();
        logic chg;
        @(posedge clk);
        period_start <= 1'b1;
        @(posedge clk);
        period_start <= 1'b0;
        chg = (act[0] != stage[0]) || (act[1] != stage[1]);
        act = stage;
        // applied and pending settle after the apply edge; look mid-cycle
        @(negedge clk);
        `CHK(applied, chg)
        `CHK(pend, 2'b00)
        repeat (2) @(posedge clk);
    endtask

    task automatic check_edges();
        pet_edge_s x;
        int        f;
        for (int e = 0; e < 4; e++) begin
            f = (act[e / 2] >> ((e % 2) ? 0 : 4)) & 15;
            x.negative = f[3];
            x.code = f[2:0];
            x.offset_ns = 7'(f[3] ? -(f % 8) * 5 : (f % 8) * 5);
            `CHK(eo[e], x)
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        stage = '{0, 0};
        act = '{0, 0};
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        check_edges();
        get(0);
        get(1);
        // first sixteen passes walk every polarity and code through edges seven and eight
        for (int i = 0; i < 24; i++) begin
            put(0, i < 16 ? {4'(i), 4'(15 - i)} : 8'(xorshift()));
            put(1, 8'(xorshift()));
            check_edges();
            get(0);
            get(1);
            `CHK(pend, 2'b11)
            pulse();
            check_edges();
        end
        // unmapped word: refused with an error, trims untouched
        apb(1'b1, 12'h1B8, 32'h000000FF);
        `CHK(er, 1'b1)
        apb(1'b0, 12'h1B8, 32'h0);
        `CHK({er, rd}, {1'b1, 32'h0})
        // status word reports active trims and pending flags
        apb(1'b0, PET_ADDR_STATUS, 32'h0);
        `CHK({er, rd}, {1'b0, 32'((act[1] << PET_STAT_ACT910_LSB) | (act[0] << PET_STAT_ACT78_LSB))})
        // apply strobe moves staging to the edges without a period start
        put(0, 8'(xorshift()));
        apb(1'b0, PET_ADDR_STATUS, 32'h0);
        `CHK(rd, 32'((act[1] << PET_STAT_ACT910_LSB) | (act[0] << PET_STAT_ACT78_LSB) | (1 << PET_STAT_PEND_LSB)))
        apb(1'b1, PET_ADDR_CTRL, 32'(1 << PET_CTRL_APPLY_BIT));
        act = stage;
        repeat (3) @(posedge clk);
        check_edges();
        `CHK(pend, 2'b00)
        apb(1'b0, PET_ADDR_CTRL, 32'h0);
        `CHK({er, rd}, {1'b0, 32'h0})
        // immediate mode: a trim write reaches the edges without any apply
        apb(1'b1, PET_ADDR_CTRL, 32'(1 << PET_CTRL_IMM_BIT));
        apb(1'b0, PET_ADDR_CTRL, 32'h0);
        `CHK({er, rd}, {1'b0, 32'(1 << PET_CTRL_IMM_BIT)})
        put(1, 8'(xorshift()));
        act = stage;
        repeat (3) @(posedge clk);
        check_edges();
        apb(1'b0, PET_ADDR_STATUS, 32'h0);
        `CHK({er, rd}, {1'b0, 32'((act[1] << PET_STAT_ACT910_LSB) | (act[0] << PET_STAT_ACT78_LSB))})
        apb(1'b1, PET_ADDR_CTRL, 32'h0);
        // reset in mid-run returns trims and edges to their reset values
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        stage = '{int'(PET_TRIM_78_RST), int'(PET_TRIM_910_RST)};
        act = stage;
        check_edges();
        `CHK({pend, applied}, 3'b000)
        get(0);
        get(1);
        end_sim();
    end

    initial begin
        repeat (4000) @(posedge clk);
        err_total++;
        end_sim();
    end
endmodule
